// file: csar_pkg.sv
// Shared constants and types for the cell scan result and alert register bank
package csar_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned OSC_HZ = 32_768;
  localparam int unsigned REF_WIN_PERIODS = 4;
  localparam int unsigned REF_WIN_CYC = REF_WIN_PERIODS * CLK_HZ / OSC_HZ;
  localparam int unsigned REF_EDGES = 4;
  localparam int unsigned HB_DIV = 2;
  localparam int unsigned HB_NOM_CYC = HB_DIV * CLK_HZ / OSC_HZ;
  localparam int unsigned HB_TOL_PERMILLE = 125;
  localparam int unsigned HB_MIN_CYC = HB_NOM_CYC * 1000 / (1000 + HB_TOL_PERMILLE);
  localparam int unsigned HB_MAX_CYC = HB_NOM_CYC * 1000 / (1000 - HB_TOL_PERMILLE);
  // Sizes
  localparam int unsigned CELLS = 12;
  localparam int unsigned AUXS = 2;
  localparam int unsigned RES_W = 12;
  localparam int unsigned CH_W = 4;
  localparam int unsigned EV_W = 3;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CELLEN = 8'h09;
  localparam logic [7:0] IDX_SCAN = 8'h0d;
  localparam logic [7:0] IDX_FMON = 8'h0e;
  localparam logic [7:0] IDX_BCAST = 8'h0f;
  localparam logic [7:0] IDX_TOTAL = 8'h10;
  localparam logic [7:0] IDX_MAXC = 8'h11;
  localparam logic [7:0] IDX_MINC = 8'h12;
  localparam logic [7:0] IDX_OVCLR = 8'h18;
  localparam logic [7:0] IDX_OVSET = 8'h19;
  localparam logic [7:0] IDX_UVSET = 8'h1a;
  localparam logic [7:0] IDX_UVCLR = 8'h1b;
  localparam logic [7:0] IDX_SPREAD = 8'h1c;
  localparam logic [7:0] IDX_HOT = 8'h1e;
  localparam logic [7:0] IDX_CTRL = 8'h30;
  localparam logic [7:0] IDX_ALST = 8'h31;
  localparam logic [7:0] IDX_IST = 8'h32;
  localparam logic [7:0] IDX_ICLR = 8'h33;
  localparam logic [7:0] IDX_IEN = 8'h34;
  // Fault-monitor layout: each mask sits eight bits above its alert
  localparam logic [15:0] FM_MASKS = 16'hd300;
  localparam logic [15:0] FM_ALERTS = 16'h00d3;
  localparam logic [15:0] FM_KEEP = 16'h2c2c;
  localparam logic [15:0] FM_GATED = 16'h00c3;
  localparam int unsigned FM_MASK_SHIFT = 8;
  localparam int unsigned FM_PUMP = 7;
  localparam int unsigned FM_HB = 6;
  localparam int unsigned FM_REF = 4;
  localparam int unsigned FM_SUP = 1;
  localparam int unsigned FM_GND = 0;
  // Field positions
  localparam int unsigned TH_LSB = 4;
  localparam int unsigned CTRL_RST_BIT = 0;
  localparam int unsigned CTRL_BUSY_BIT = 8;
  localparam int unsigned CTRL_AUX_LSB = 16;
  localparam int unsigned ALST_UV_LSB = 16;
  localparam int unsigned ALST_SPREAD_BIT = 28;
  localparam int unsigned ALST_HOT_BIT = 29;
  localparam int unsigned EV_SCAN = 0;
  localparam int unsigned EV_THR = 1;
  localparam int unsigned EV_FAULT = 2;
  // Reset values
  localparam logic [7:0] BCAST_RST = 8'h40;
  localparam logic [11:0] CELLEN_RST = 12'hfff;
  localparam logic [11:0] TH_HIGH_RST = 12'hfff;
  localparam logic [11:0] TH_LOW_RST = 12'h000;
  localparam logic [11:0] SPREAD_OFF = 12'hfff;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_COMMIT = 2'b10
  } csar_state_t;
endpackage

// file: csar_regs.sv
// Cell scan sequencing, result summary, threshold and fault-monitor alert registers on APB
//
// Contract
// - A fault-monitor mask bit lets its alert drive the alarm; cleared mask blocks it.
// - Pump, heartbeat, supply and ground alerts stay clear while the reset flag is set.
// - Writing 1 to an alert bit keeps it; writing 0 clears it.
// - Heartbeat alert when pulse rate is off by more than 12.5 percent of nominal.
// - After each converter strobe count reference edges four slow periods; four sets alert.
// - Unused fault-monitor bits store and return what software wrote.
// - Group address in low byte, default 0x40, LSB ignored, upper byte reads zero.
// - Total is the 16-bit sum of all cells enabled in the scan.
// - Highest result in bits 15..4, cell number below; ties pick highest cell.
// - Lowest result in bits 15..4, cell number below; ties pick highest cell.
// - Overvoltage alert sets above trip level, clears only below release level.
// - Undervoltage alert sets below trip level, clears only above release level.
// - Thresholds hold 12 bits in 15..4; low nibble ignores writes, reads zero.
// - Spread alert when highest minus lowest exceeds the spread threshold.
// - Spread threshold 0xfff0 disables and clears at once; other changes wait a scan.
// - Hot alert when an enabled auxiliary result is below the hot threshold.
// - A scan start is taken only while idle; during a scan it is ignored.
// - Channels disabled for a scan keep their previous results.
`timescale 1ns/1ps
module csar_regs
  import csar_pkg::*;
#(
  parameter int unsigned REF_WIN_CYC_P = csar_pkg::REF_WIN_CYC,
  parameter int unsigned HB_MIN_CYC_P = csar_pkg::HB_MIN_CYC,
  parameter int unsigned HB_MAX_CYC_P = csar_pkg::HB_MAX_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter handshake
  output logic adc_strobe,
  output logic [csar_pkg::CH_W-1:0] adc_chan,
  input wire logic adc_done,
  input wire logic [csar_pkg::RES_W-1:0] adc_data,
  // Fault monitor inputs
  input wire logic ref_pin,
  input wire logic heartbeat_in,
  input wire logic pump_low_in,
  input wire logic supply_open_in,
  input wire logic ground_open_in,
  // Alarm and interrupt
  output logic alarm,
  output logic irq
);
  import csar_pkg::*;

  localparam int unsigned RCW = $clog2(REF_WIN_CYC_P + 1);
  localparam int unsigned HCW = $clog2(HB_MAX_CYC_P + 2);
  localparam int unsigned SCW = CELLS + AUXS;

  typedef struct packed {
    csar_state_t st;
    logic [CH_W-1:0] chan;
    logic [SCW-1:0] smask;
    logic [CELLS-1:0][RES_W-1:0] cells;
    logic [AUXS-1:0][RES_W-1:0] aux;
    logic [15:0] fm;
    logic rst_flag;
    logic [7:0] bcast;
    logic [CELLS-1:0] cellen;
    logic [AUXS-1:0] auxen;
    logic [RES_W-1:0] ovclr;
    logic [RES_W-1:0] ovset;
    logic [RES_W-1:0] uvset;
    logic [RES_W-1:0] uvclr;
    logic [RES_W-1:0] spread;
    logic [RES_W-1:0] hot;
    logic [15:0] total;
    logic [15:0] maxc;
    logic [15:0] minc;
    logic [CELLS-1:0] ov;
    logic [CELLS-1:0] uv;
    logic spr_al;
    logic hot_al;
    logic [EV_W-1:0] ist;
    logic [EV_W-1:0] ien;
    logic [RCW-1:0] ref_cnt;
    logic [2:0] ref_edges;
    logic ref_prev;
    logic [HCW-1:0] hb_cnt;
    logic hb_prev;
    logic hb_seen;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic strobe;
    logic alarm;
    logic irq;
  } csar_st_t;

  csar_st_t r_r;
  csar_st_t r_nxt;

  function automatic logic [31:0] merge32(input logic [31:0] o, input logic [31:0] w, input logic [31:0] m);
    return (o & ~m) | (w & m);
  endfunction

  // Lowest enabled channel at or above start; bit 4 says one was found
  function automatic logic [CH_W:0] next_chan(input logic [SCW-1:0] mask, input logic [CH_W-1:0] start);
    logic [CH_W:0] res;
    res = '0;
    for (int i = SCW - 1; i >= 0; i--) begin
      if (mask[i] && i >= int'(start)) begin
        res = {1'b1, CH_W'(i)};
      end
    end
    return res;
  endfunction

  function automatic logic reg_known(input logic [7:0] idx);
    case (idx)
      IDX_CELLEN, IDX_SCAN, IDX_FMON, IDX_BCAST, IDX_TOTAL, IDX_MAXC, IDX_MINC,
      IDX_OVCLR, IDX_OVSET, IDX_UVSET, IDX_UVCLR, IDX_SPREAD, IDX_HOT,
      IDX_CTRL, IDX_ALST, IDX_IST, IDX_ICLR, IDX_IEN: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  always_comb begin
    logic [31:0] wm;
    logic [31:0] rd;
    logic [7:0] idx;
    logic hit;
    logic wr;
    logic go;
    logic ref_rise;
    logic hb_rise;
    logic any_c;
    logic [15:0] fm_set;
    logic [15:0] sum;
    logic [RES_W-1:0] mx;
    logic [RES_W-1:0] mn;
    logic [CH_W-1:0] mxi;
    logic [CH_W-1:0] mni;
    logic [CH_W:0] nx;
    logic [EV_W-1:0] ev;
    r_nxt = r_r;
    wm = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    rd = '0;
    idx = paddr[9:2];
    hit = reg_known(idx) && paddr[11:10] == 2'b00 && paddr[1:0] == 2'b00;
    wr = psel && penable && r_r.pready && pwrite && hit;
    go = 1'b0;
    ref_rise = ref_pin && !r_r.ref_prev;
    hb_rise = heartbeat_in && !r_r.hb_prev;
    any_c = 1'b0;
    fm_set = '0;
    sum = '0;
    mx = '0;
    mn = '1;
    mxi = '0;
    mni = '0;
    nx = '0;
    ev = '0;
    r_nxt.strobe = 1'b0;

    // Read data is captured in the setup cycle so that prdata comes from a flop
    case (idx)
      IDX_CELLEN: rd = 32'(r_r.cellen);
      IDX_FMON: rd = 32'(r_r.fm);
      IDX_BCAST: rd = 32'(r_r.bcast);
      IDX_TOTAL: rd = 32'(r_r.total);
      IDX_MAXC: rd = 32'(r_r.maxc);
      IDX_MINC: rd = 32'(r_r.minc);
      IDX_OVCLR: rd = 32'({r_r.ovclr, 4'h0});
      IDX_OVSET: rd = 32'({r_r.ovset, 4'h0});
      IDX_UVSET: rd = 32'({r_r.uvset, 4'h0});
      IDX_UVCLR: rd = 32'({r_r.uvclr, 4'h0});
      IDX_SPREAD: rd = 32'({r_r.spread, 4'h0});
      IDX_HOT: rd = 32'({r_r.hot, 4'h0});
      IDX_CTRL: begin
        rd[CTRL_RST_BIT] = r_r.rst_flag;
        rd[CTRL_BUSY_BIT] = r_r.st != ST_IDLE;
        rd[CTRL_AUX_LSB +: AUXS] = r_r.auxen;
      end
      IDX_ALST: begin
        rd[CELLS-1:0] = r_r.ov;
        rd[ALST_UV_LSB +: CELLS] = r_r.uv;
        rd[ALST_SPREAD_BIT] = r_r.spr_al;
        rd[ALST_HOT_BIT] = r_r.hot_al;
      end
      IDX_IST: rd = 32'(r_r.ist);
      IDX_IEN: rd = 32'(r_r.ien);
      default: rd = '0;
    endcase
    if (psel && !penable) begin
      r_nxt.pready = 1'b1;
      r_nxt.prdata = rd;
      r_nxt.pslverr = !hit;
    end else begin
      r_nxt.pready = 1'b0;
      r_nxt.pslverr = 1'b0;
    end

    // Register writes take effect at the access edge
    if (wr) begin
      case (idx)
        IDX_CELLEN: r_nxt.cellen = CELLS'(merge32(32'(r_r.cellen), pwdata, wm));
        IDX_SCAN: go = pwdata[0] && pstrb[0];
        IDX_FMON: begin
          r_nxt.fm = 16'(merge32(32'(r_r.fm), pwdata, wm & 32'(FM_MASKS | FM_KEEP)));
          r_nxt.fm = r_nxt.fm & ~(16'(wm) & ~pwdata[15:0] & FM_ALERTS);
        end
        IDX_BCAST: r_nxt.bcast = 8'(merge32(32'(r_r.bcast), pwdata, wm));
        IDX_OVCLR: r_nxt.ovclr = RES_W'(merge32(32'(r_r.ovclr), pwdata >> TH_LSB, wm >> TH_LSB));
        IDX_OVSET: r_nxt.ovset = RES_W'(merge32(32'(r_r.ovset), pwdata >> TH_LSB, wm >> TH_LSB));
        IDX_UVSET: r_nxt.uvset = RES_W'(merge32(32'(r_r.uvset), pwdata >> TH_LSB, wm >> TH_LSB));
        IDX_UVCLR: r_nxt.uvclr = RES_W'(merge32(32'(r_r.uvclr), pwdata >> TH_LSB, wm >> TH_LSB));
        IDX_SPREAD: r_nxt.spread = RES_W'(merge32(32'(r_r.spread), pwdata >> TH_LSB, wm >> TH_LSB));
        IDX_HOT: r_nxt.hot = RES_W'(merge32(32'(r_r.hot), pwdata >> TH_LSB, wm >> TH_LSB));
        IDX_CTRL: begin
          if (wm[CTRL_RST_BIT] && !pwdata[CTRL_RST_BIT]) begin
            r_nxt.rst_flag = 1'b0;
          end
          r_nxt.auxen = AUXS'(merge32(32'(r_r.auxen), pwdata >> CTRL_AUX_LSB, wm >> CTRL_AUX_LSB));
        end
        IDX_ICLR: r_nxt.ist = r_r.ist & ~EV_W'(pwdata & wm);
        IDX_IEN: r_nxt.ien = EV_W'(merge32(32'(r_r.ien), pwdata, wm));
        default: r_nxt.ist = r_nxt.ist;
      endcase
    end
    // Disabling the spread check drops the alert in the same edge
    if (r_nxt.spread == SPREAD_OFF) begin
      r_nxt.spr_al = 1'b0;
    end

    // Scan sequencer
    case (r_r.st)
      ST_IDLE: begin
        if (go) begin
          r_nxt.smask = {r_r.auxen, r_r.cellen};
          nx = next_chan({r_r.auxen, r_r.cellen}, '0);
          r_nxt.chan = nx[CH_W-1:0];
          r_nxt.strobe = nx[CH_W];
          r_nxt.st = nx[CH_W] ? ST_CONV : ST_COMMIT;
        end
      end
      ST_CONV: begin
        if (adc_done) begin
          // Only the converted channel is written; disabled channels keep old data
          if (r_r.chan < CH_W'(CELLS)) begin
            r_nxt.cells[r_r.chan] = adc_data;
          end else begin
            r_nxt.aux[1'(r_r.chan - CH_W'(CELLS))] = adc_data;
          end
          nx = next_chan(r_r.smask, CH_W'(r_r.chan + 1'b1));
          r_nxt.chan = nx[CH_W-1:0];
          r_nxt.strobe = nx[CH_W];
          r_nxt.st = nx[CH_W] ? ST_CONV : ST_COMMIT;
        end
      end
      ST_COMMIT: begin
        // Everything derived from the scan lands in one edge
        for (int i = 0; i < CELLS; i++) begin
          if (r_r.smask[i]) begin
            any_c = 1'b1;
            sum = 16'(sum + 16'(r_r.cells[i]));
            if (r_r.cells[i] >= mx) begin
              mx = r_r.cells[i];
              mxi = CH_W'(i + 1);
            end
            if (r_r.cells[i] <= mn) begin
              mn = r_r.cells[i];
              mni = CH_W'(i + 1);
            end
            if (r_r.cells[i] > r_r.ovset) begin
              r_nxt.ov[i] = 1'b1;
            end else if (r_r.cells[i] < r_r.ovclr) begin
              r_nxt.ov[i] = 1'b0;
            end
            if (r_r.cells[i] < r_r.uvset) begin
              r_nxt.uv[i] = 1'b1;
            end else if (r_r.cells[i] > r_r.uvclr) begin
              r_nxt.uv[i] = 1'b0;
            end
          end
        end
        r_nxt.total = sum;
        if (any_c) begin
          r_nxt.maxc = {mx, mxi};
          r_nxt.minc = {mn, mni};
        end
        r_nxt.spr_al = any_c && r_nxt.spread != SPREAD_OFF && (mx - mn) > r_nxt.spread;
        r_nxt.hot_al = (r_r.smask[CELLS] && r_r.aux[0] < r_r.hot)
                       || (r_r.smask[CELLS+1] && r_r.aux[1] < r_r.hot);
        ev[EV_SCAN] = 1'b1;
        ev[EV_THR] = |(r_nxt.ov & ~r_r.ov) || |(r_nxt.uv & ~r_r.uv)
                     || (r_nxt.spr_al && !r_r.spr_al) || (r_nxt.hot_al && !r_r.hot_al);
        r_nxt.st = ST_IDLE;
      end
      default: r_nxt.st = ST_IDLE;
    endcase

    // Reference pin oscillation window, restarted by every converter strobe
    r_nxt.ref_prev = ref_pin;
    if (r_r.strobe) begin
      r_nxt.ref_cnt = RCW'(REF_WIN_CYC_P);
      r_nxt.ref_edges = '0;
    end else if (r_r.ref_cnt != '0) begin
      r_nxt.ref_cnt = RCW'(r_r.ref_cnt - 1'b1);
      if (ref_rise) begin
        r_nxt.ref_edges = 3'(r_r.ref_edges + 1'b1);
        fm_set[FM_REF] = r_nxt.ref_edges == 3'(REF_EDGES);
      end
    end

    // Heartbeat period check; a stalled heartbeat trips once the count passes the upper bound
    r_nxt.hb_prev = heartbeat_in;
    if (hb_rise) begin
      r_nxt.hb_seen = 1'b1;
      r_nxt.hb_cnt = HCW'(1);
      fm_set[FM_HB] = r_r.hb_seen && (r_r.hb_cnt < HCW'(HB_MIN_CYC_P) || r_r.hb_cnt > HCW'(HB_MAX_CYC_P));
    end else if (r_r.hb_cnt <= HCW'(HB_MAX_CYC_P)) begin
      r_nxt.hb_cnt = HCW'(r_r.hb_cnt + 1'b1);
    end else begin
      fm_set[FM_HB] = r_r.hb_seen;
    end
    fm_set[FM_PUMP] = pump_low_in;
    fm_set[FM_SUP] = supply_open_in;
    fm_set[FM_GND] = ground_open_in;
    if (r_r.rst_flag) begin
      fm_set = fm_set & ~FM_GATED;
    end
    // Hardware set wins over a software clear in the same edge
    r_nxt.fm = r_nxt.fm | fm_set;
    ev[EV_FAULT] = |(fm_set & ~r_r.fm);
    r_nxt.ist = r_nxt.ist | ev;

    r_nxt.alarm = |((r_nxt.fm >> FM_MASK_SHIFT) & r_nxt.fm & FM_ALERTS);
    r_nxt.irq = |(r_nxt.ist & r_nxt.ien);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_r <= '0;
      r_r.st <= ST_IDLE;
      r_r.rst_flag <= 1'b1;
      r_r.bcast <= BCAST_RST;
      r_r.cellen <= CELLEN_RST;
      r_r.ovclr <= TH_HIGH_RST;
      r_r.ovset <= TH_HIGH_RST;
      r_r.uvset <= TH_LOW_RST;
      r_r.uvclr <= TH_LOW_RST;
      r_r.spread <= SPREAD_OFF;
      r_r.hot <= TH_LOW_RST;
      r_r.minc <= '1;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign prdata = r_r.prdata;
  assign pready = r_r.pready;
  assign pslverr = r_r.pslverr;
  assign adc_strobe = r_r.strobe;
  assign adc_chan = r_r.chan;
  assign alarm = r_r.alarm;
  assign irq = r_r.irq;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence commit_s;
    r_r.st == ST_COMMIT && |r_r.smask[CELLS-1:0];
  endsequence

  sequence fm_wr_s;
    psel && penable && pready && pwrite && paddr == {2'b00, IDX_FMON, 2'b00};
  endsequence

  alarm_mask_a: assert property ((r_r.fm[15:8] & r_r.fm[7:0] & FM_ALERTS[7:0]) == 8'h00 |-> !alarm)
    else $error("alarm raised with no enabled alert");
  rst_gate_a: assert property (r_r.rst_flag |-> (r_r.fm & FM_GATED) == 16'h0000)
    else $error("gated alert set before reset flag cleared");
  write_one_a: assert property (fm_wr_s and (pstrb[0] && pwdata[FM_PUMP] && r_r.fm[FM_PUMP]) |=> r_r.fm[FM_PUMP])
    else $error("writing one cleared an alert");
  ref_idle_a: assert property (r_r.ref_cnt == '0 && !r_r.fm[FM_REF] |=> !r_r.fm[FM_REF])
    else $error("reference alert set outside a strobe window");
  bcast_high_a: assert property (pready && !pwrite && paddr == {2'b00, IDX_BCAST, 2'b00} |-> prdata[31:8] == '0)
    else $error("address upper bits not zero");
  thr_nibble_a: assert property (pready && paddr[9:2] == IDX_OVSET |-> prdata[3:0] == 4'h0)
    else $error("threshold low nibble not zero");
  max_min_a: assert property (commit_s |=> r_r.maxc[15:4] >= r_r.minc[15:4])
    else $error("highest below lowest after scan");
  ov_set_a: assert property (commit_s and (r_r.smask[0] && r_r.cells[0] > r_r.ovset) |=> r_r.ov[0])
    else $error("overvoltage alert missed");
  uv_set_a: assert property (commit_s and (r_r.smask[0] && r_r.cells[0] < r_r.uvset) |=> r_r.uv[0])
    else $error("undervoltage alert missed");
  spread_off_a: assert property (r_r.spread == SPREAD_OFF |-> !r_r.spr_al)
    else $error("spread alert while disabled");
  hot_set_a: assert property (r_r.st == ST_COMMIT && r_r.smask[CELLS] && r_r.aux[0] < r_r.hot |=> r_r.hot_al)
    else $error("hot alert missed");
  // A start taken mid-scan would restart the channel walk and pulse the strobe
  busy_ignore_a: assert property (r_r.st == ST_CONV && !adc_done
                                  |=> r_r.st == ST_CONV && !adc_strobe && adc_chan == $past(adc_chan))
    else $error("scan start taken while busy");
  keep_cell_a: assert property (r_r.st == ST_CONV && r_r.chan != '0 |=> r_r.cells[0] == $past(r_r.cells[0]))
    else $error("unconverted cell changed");
  total_commit_a: assert property ($changed(r_r.total) |-> $past(r_r.st) == ST_COMMIT)
    else $error("total changed outside scan end");
endmodule // csar_regs

// file: cell_scan_alert_registers_tb_top.sv
// Self-checking bench for the cell scan result and alert register bank
`timescale 1ns/1ps
module cell_scan_alert_registers_tb_top;
  import csar_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, adc_strobe, adc_done = 0, alarm, irq, err;
  logic [3:0] adc_chan;
  logic [11:0] adc_data = 0;
  logic ref_pin = 0, hb = 0, rtog = 0, ht = 0, spd = 0;
  logic [2:0] flt = 0;
  logic [11:0] ov = 0, uv = 0;
  logic [11:0] res [14];
  logic [7:0] thi [6] = '{IDX_OVCLR, IDX_OVSET, IDX_UVSET, IDX_UVCLR, IDX_SPREAD, IDX_HOT};
  logic [11:0] thv [6] = '{12'ha00, 12'hc00, 12'h300, 12'h500, 12'h800, 12'h400};
  logic [7:0] al;
  logic [15:0] m;
  int fb [3] = '{7, 1, 0};
  int failures = 0, n_compared = 0, seed = 72226, cyc = 0, nstb = 0, dly = 0, hbp = 30;

  // Short windows keep the oscillator-based detectors within a brief run
  csar_regs #(.REF_WIN_CYC_P(40), .HB_MIN_CYC_P(20), .HB_MAX_CYC_P(40)) csar_regs_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .adc_strobe(adc_strobe), .adc_chan(adc_chan), .adc_done(adc_done),
    .adc_data(adc_data), .ref_pin(ref_pin), .heartbeat_in(hb), .pump_low_in(flt[2]),
    .supply_open_in(flt[1]), .ground_open_in(flt[0]), .alarm(alarm), .irq(irq));

  always #5 pclk = ~pclk;

  always begin
    repeat (hbp / 2) @(posedge pclk);
    hb <= ~hb;
  end

  always @(posedge pclk) begin
    if (rtog) ref_pin <= ~ref_pin;
  end

  // Converter stand-in: answers each strobe after dly cycles
  always @(posedge pclk) begin
    if (adc_strobe === 1'b1) begin
      nstb <= nstb + 1;
      repeat (dly) @(posedge pclk);
      adc_done <= 1;
      adc_data <= res[adc_chan];
      @(posedge pclk);
    end
    adc_done <= 0;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures = failures + 1;
      finish_test();
    end
  end

  task finish_test();
    if (failures == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // Only the bench timeout ends a wait for the slave
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1, idx, d);
  endtask

  task rdx(input logic [7:0] idx, input logic [31:0] e);
    apb(0, idx, 0);
    chk(rd, e);
  endtask

  task scan(input logic [11:0] en, input logic [1:0] aux);
    int tot, mx, mn, mxc, mnc, n0;
    wr(IDX_CELLEN, en);
    wr(IDX_CTRL, {14'h0, aux, 16'h0});
    n0 = nstb;
    tot = 0;
    mx = 0;
    mn = 4095;
    for (int i = 0; i < 12; i++) begin
      if (en[i]) begin
        tot += res[i];
        if (res[i] >= mx) mxc = i + 1;
        if (res[i] >= mx) mx = res[i];
        if (res[i] <= mn) mnc = i + 1;
        if (res[i] <= mn) mn = res[i];
        if (res[i] > thv[1]) ov[i] = 1;
        else if (res[i] < thv[0]) ov[i] = 0;
        if (res[i] < thv[2]) uv[i] = 1;
        else if (res[i] > thv[3]) uv[i] = 0;
      end
    end
    spd = (thv[4] != 12'hfff) && (mx - mn > thv[4]);
    ht = (aux[0] && res[12] < thv[5]) || (aux[1] && res[13] < thv[5]);
    wr(IDX_SCAN, 1);
    // Second start lands mid-scan and must leave no trace
    wr(IDX_SCAN, 1);
    repeat (300) begin
      apb(0, IDX_CTRL, 0);
      if (rd[8] === 1'b0) break;
    end
    chk(nstb - n0, $countones(en) + $countones(aux));
    rdx(IDX_TOTAL, tot);
    rdx(IDX_MAXC, {mx[11:0], mxc[3:0]});
    rdx(IDX_MINC, {mn[11:0], mnc[3:0]});
    rdx(IDX_ALST, {2'b0, ht, spd, uv, 4'h0, ov});
  endtask

  initial begin
    foreach (res[i]) res[i] = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    flt <= 3'b111;
    rdx(IDX_BCAST, 32'h40);
    rdx(IDX_OVSET, 32'hfff0);
    rdx(IDX_MINC, 32'hffff);
    apb(0, IDX_FMON, 0);
    chk(rd & FM_ALERTS, 0);
    apb(0, 8'h05, 0);
    chk({rd[30:0], err}, 1);
    wr(IDX_BCAST, 32'hffff_ffff);
    apb(0, IDX_BCAST, 0);
    chk(rd & 32'hffff_fffe, 32'hfe);
    // Lane 0 not strobed: the address byte must keep its value
    pstrb <= 4'he;
    wr(IDX_BCAST, 0);
    pstrb <= 4'hf;
    apb(0, IDX_BCAST, 0);
    chk(rd & 32'hffff_fffe, 32'hfe);
    foreach (thi[k]) wr(thi[k], {thv[k], 4'hf});
    foreach (thi[k]) rdx(thi[k], {thv[k], 4'h0});
    wr(IDX_CTRL, 0);
    repeat (3) @(posedge pclk);
    flt <= 0;
    al = 8'h83;
    foreach (fb[k]) begin
      m = 16'h100 << fb[k];
      wr(IDX_FMON, 16'h2cff | m);
      rdx(IDX_FMON, 16'h2c2c | m | al);
      chk(alarm, 1);
      al[fb[k]] = 0;
      wr(IDX_FMON, (16'h2cff | m) & ~(16'h1 << fb[k]));
      rdx(IDX_FMON, 16'h2c2c | m | al);
      chk(alarm, 0);
    end
    hbp = 8;
    repeat (60) @(posedge pclk);
    hbp = 30;
    repeat (60) @(posedge pclk);
    apb(0, IDX_FMON, 0);
    chk(rd[6], 1);
    wr(IDX_FMON, 16'h2c00);
    repeat (90) @(posedge pclk);
    apb(0, IDX_FMON, 0);
    chk(rd[6], 0);
    rtog = 1;
    repeat (30) @(posedge pclk);
    apb(0, IDX_FMON, 0);
    chk(rd[4], 0);
    dly = 30;
    scan(12'hfff, 2'b11);
    rtog = 0;
    dly = 0;
    apb(0, IDX_FMON, 0);
    chk(rd[4], 1);
    chk(irq, 0);
    wr(IDX_IEN, 1);
    apb(0, IDX_IST, 0);
    chk({rd[0], irq}, 2'b11);
    wr(IDX_ICLR, 7);
    apb(0, IDX_IST, 0);
    chk({rd[0], irq}, 0);
    for (int k = 0; k < 8; k++) begin
      foreach (res[i]) res[i] = k ? 12'($random(seed)) : 12'h5a5;
      scan(12'($random(seed)) | 12'h801, 2'($random(seed)));
    end
    res[0] = 12'h100;
    res[1] = 12'hf00;
    scan(12'h003, 2'b00);
    wr(IDX_SPREAD, 16'h0ff0);
    rdx(IDX_ALST, {2'b0, ht, spd, uv, 4'h0, ov});
    wr(IDX_SPREAD, 16'hfff0);
    spd = 0;
    rdx(IDX_ALST, {2'b0, ht, spd, uv, 4'h0, ov});
    finish_test();
  end
endmodule // cell_scan_alert_registers_tb_top
